// File: rtl/dcad_defines.vh
// Offsets, field positions, opcodes and reset values of the DSP ALU datapath.
`ifndef DCAD_DEFINES_VH
`define DCAD_DEFINES_VH

// Register byte offsets on the APB slave.
`define DCAD_OFS_CMD 12'h000
`define DCAD_OFS_STATUS 12'h004
`define DCAD_OFS_FREG 12'h008
`define DCAD_OFS_ACCA 12'h00C
`define DCAD_OFS_ACCB 12'h010
`define DCAD_OFS_PFCFG 12'h014
`define DCAD_OFS_WBASE 12'h040
`define DCAD_OFS_WLAST 12'h07C

// Reset values.
`define DCAD_RST_WORD 32'h0000_0000
`define DCAD_RST_HALF 16'h0000

// Status register bit positions.
`define DCAD_ST_C 0
`define DCAD_ST_DC 1
`define DCAD_ST_N 2
`define DCAD_ST_OV 3
`define DCAD_ST_Z 4
`define DCAD_ST_OA 5
`define DCAD_ST_OB 6
`define DCAD_ST_SA 7
`define DCAD_ST_SB 8
`define DCAD_ST_BUSY 9
`define DCAD_ST_ILLEGAL 10
`define DCAD_ST_TAKEN 11
`define DCAD_ST_REFUSED 12

// Opcodes held in command bits 4..0.
`define DCAD_OP_ADD_F 5'h00
`define DCAD_OP_ADD_WITH_CARRY_OP_F 5'h01
`define DCAD_OP_ADD_L10 5'h02
`define DCAD_OP_ADD_WITH_CARRY_OP_L10 5'h03
`define DCAD_OP_ADD_WWW 5'h04
`define DCAD_OP_ADD_WITH_CARRY_OP_WWW 5'h05
`define DCAD_OP_ADD_L5 5'h06
`define DCAD_OP_ADD_WITH_CARRY_OP_L5 5'h07
`define DCAD_OP_ADD_ACC 5'h08
`define DCAD_OP_AND_WWW 5'h09
`define DCAD_OP_AND_L10 5'h0A
`define DCAD_OP_ASR_F 5'h0B
`define DCAD_OP_ASR_W 5'h0C
`define DCAD_OP_ASR_BW 5'h0D
`define DCAD_OP_ASR_BL 5'h0E
`define DCAD_OP_MPY_SQR 5'h0F
`define DCAD_OP_MPY_PAIR 5'h10
`define DCAD_OP_BRA_CC 5'h11

// Branch condition codes held in literal bits 3..0.
`define DCAD_CC_C 4'h0
`define DCAD_CC_GE 4'h1
`define DCAD_CC_GEU 4'h2
`define DCAD_CC_GT 4'h3
`define DCAD_CC_Z 4'h4

// Prefetch modes.
`define DCAD_PF_NONE 4'h0
`define DCAD_PF_PLAIN 4'h1
`define DCAD_PF_INDEX 4'h8

// ALU function selects.
`define DCAD_ALU_ADD 2'h0
`define DCAD_ALU_AND 2'h1
`define DCAD_ALU_ASR1 2'h2
`define DCAD_ALU_ASRN 2'h3

// Saturation limits of the 32-bit accumulators.
`define DCAD_ACC_MAX 32'h7FFF_FFFF
`define DCAD_ACC_MIN 32'h8000_0000

`endif

// File: rtl/dcad_alu.v
// Combinational 16-bit add, AND and arithmetic shift unit with status flags.
`include "dcad_defines.vh"

module dcad_alu (
  // Operands.
  input wire [15:0] a_in,
  input wire [15:0] b_in,
  input wire carry_in,
  input wire [4:0] shamt_in,
  input wire [1:0] sel_in,
  // Result and flags, order C, DC, N, OV, Z.
  output reg [15:0] res_out,
  output wire [4:0] flags_out
);

  wire [16:0] sum;
  wire [4:0] nib;
  reg c_f;
  reg dc_f;
  reg ov_f;

  assign sum = {1'b0, a_in} + {1'b0, b_in} + {16'h0000, carry_in};
  assign nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};

  // Select the function; the caller masks the flags each one affects.
  always @* begin
    res_out = sum[15:0];
    c_f = sum[16];
    dc_f = nib[4];
    ov_f = (a_in[15] == b_in[15]) && (sum[15] != a_in[15]);
    case (sel_in)
      `DCAD_ALU_AND: begin
        res_out = a_in & b_in;
      end
      `DCAD_ALU_ASR1: begin
        res_out = {a_in[15], a_in[15:1]};
        c_f = a_in[0];
        ov_f = 1'b0;
      end
      `DCAD_ALU_ASRN: begin
        res_out = $signed(a_in) >>> shamt_in;
      end
      default: begin
        res_out = sum[15:0];
      end
    endcase
  end

  assign flags_out = {res_out == 16'h0000, ov_f, res_out[15], dc_f, c_f};

endmodule

// File: rtl/dcad_core.v
// DSP core ALU operand datapath with APB register access and prefetch.
// Function
// - Square multiply accepts only the same register, four to seven.
// - Pair multiply accepts six distinct pairs from registers four to seven.
// - File register operations pair with register zero as alternative target.
// - X prefetch uses register eight or nine, adjusted, indexed or none.
// - Y prefetch uses register ten or eleven, adjusted, indexed or none.
// - Prefetched data lands only in registers four through seven.
// - Plain register fields select one of sixteen working registers.
// - Shifted signed add to accumulator touches only its overflow and saturate.
// - Add with carry to register zero keeps file, sets five flags.
// - Medium literal add with carry writes register back, five flags.
// - Three operand add with carry of short literal in one cycle.
// - Single right shift register to register sets C, N, OV, Z.
// - Single right shift of file may target register zero.
// - Barrel shift by register amount sets only N and Z.
// - Barrel shift by short literal sets only N and Z.
// - Signed greater-or-equal branch: one cycle, two when taken, no flags.
// - Unsigned greater-or-equal branch is separate and changes no flags.
// - Signed greater-than branch: one cycle, two when taken.
//
// Our own choices: the APB register port and the register addresses.
`include "dcad_defines.vh"

module dcad_core (
  // Clock and reset.
  input wire clk_in,
  input wire rst_n_in,
  // APB slave.
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  // Prefetch ports.
  output wire pf_x_en_out,
  output reg [15:0] pf_x_addr_out,
  input wire [15:0] pf_x_data_in,
  output wire pf_y_en_out,
  output reg [15:0] pf_y_addr_out,
  input wire [15:0] pf_y_data_in,
  // Core status.
  output wire busy_out,
  output reg branch_taken_out
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_BR2 = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] cmd_r;
  reg [12:0] status_r;
  reg [15:0] freg_r;
  reg [31:0] acca_r;
  reg [31:0] accb_r;
  reg [17:0] pfcfg_r;
  reg [15:0] default_work_reg_r [0:15];
  integer i;
  integer j;

  // Command fields.
  wire [4:0] op = cmd_r[4:0];
  wire [3:0] wa = cmd_r[8:5];
  wire [3:0] wb = cmd_r[12:9];
  wire [3:0] wd = cmd_r[16:13];
  wire [9:0] lit = cmd_r[26:17];
  wire acc_b = cmd_r[27];
  wire to_default_work_reg = cmd_r[28];
  // Prefetch fields.
  wire [3:0] xmode = pfcfg_r[3:0];
  wire xsel = pfcfg_r[4];
  wire [3:0] xd = pfcfg_r[8:5];
  wire [3:0] ymode = pfcfg_r[12:9];
  wire ysel = pfcfg_r[13];
  wire [3:0] yd = pfcfg_r[17:14];
  wire [3:0] xptr = {3'b100, xsel};
  wire [3:0] yptr = {3'b101, ysel};

  // APB phases.
  wire setup = psel_in && !penable_in;
  wire wr_acc = psel_in && penable_in && pwrite_in;
  wire w_hit = (paddr_in >= `DCAD_OFS_WBASE) &&
    (paddr_in <= `DCAD_OFS_WLAST) && (paddr_in[1:0] == 2'b00);
  wire [3:0] w_idx = paddr_in[5:2];
  wire idle = state_r[0];
  wire exec = state_r[1];
  wire cmd_wr = wr_acc && (paddr_in == `DCAD_OFS_CMD);

  assign pready_out = 1'b1;
  assign busy_out = !idle;

  // Post adjust amount of a prefetch pointer.
  function [15:0] pf_delta;
    input [3:0] m;
    begin
      case (m)
        4'h2: pf_delta = 16'h0002;
        4'h3: pf_delta = 16'h0004;
        4'h4: pf_delta = 16'h0006;
        4'h5: pf_delta = 16'hFFFE;
        4'h6: pf_delta = 16'hFFFC;
        4'h7: pf_delta = 16'hFFFA;
        default: pf_delta = 16'h0000;
      endcase
    end
  endfunction

  // Prefetch mode legality; indexed only on the second pointer.
  function pf_ok;
    input [3:0] m;
    input s;
    input [3:0] d;
    begin
      pf_ok = (m == `DCAD_PF_NONE) ||
        ((m < `DCAD_PF_INDEX || (m == `DCAD_PF_INDEX && s)) &&
         d >= 4'd4 && d <= 4'd7);
    end
  endfunction

  // Operand legality of multiply and prefetch encodings.
  wire is_sqr = (op == `DCAD_OP_MPY_SQR);
  wire is_mpy = is_sqr || (op == `DCAD_OP_MPY_PAIR);
  wire wa_dsp = (wa >= 4'd4) && (wa <= 4'd7);
  wire wb_dsp = (wb >= 4'd4) && (wb <= 4'd7);
  wire sqr_ok = wa_dsp && (wa == wb);
  wire pair_ok = wa_dsp && wb_dsp && (wa < wb);
  wire pfs_ok = pf_ok(xmode, xsel, xd) && pf_ok(ymode, ysel, yd);
  wire illegal = is_mpy && !((is_sqr ? sqr_ok : pair_ok) && pfs_ok);
  wire mpy_go = exec && is_mpy && !illegal;

  assign pf_x_en_out = mpy_go && (xmode != `DCAD_PF_NONE);
  assign pf_y_en_out = mpy_go && (ymode != `DCAD_PF_NONE);

  // ALU operand selection and flag masks, order C, DC, N, OV, Z.
  reg [15:0] alu_a;
  reg [15:0] alu_b;
  reg [4:0] alu_sh;
  reg [1:0] alu_sel;
  reg [4:0] fmask;
  reg res_we;
  reg res_to_f;
  reg [3:0] dst;
  wire [15:0] alu_res;
  wire [4:0] alu_flags;
  wire is_add_with_carry_op = (op <= `DCAD_OP_ADD_WITH_CARRY_OP_L5) && op[0];

  always @* begin
    alu_a = default_work_reg_r[wa];
    alu_b = default_work_reg_r[wb];
    alu_sh = 5'h01;
    alu_sel = `DCAD_ALU_ADD;
    fmask = 5'h00;
    res_we = 1'b0;
    res_to_f = 1'b0;
    dst = wd;
    case (op)
      `DCAD_OP_ADD_F, `DCAD_OP_ADD_WITH_CARRY_OP_F: begin
        alu_a = freg_r;
        alu_b = default_work_reg_r[0];
        dst = 4'd0;
        res_we = to_default_work_reg;
        res_to_f = !to_default_work_reg;
        fmask = 5'h1F;
      end
      `DCAD_OP_ADD_L10, `DCAD_OP_ADD_WITH_CARRY_OP_L10: begin
        alu_a = default_work_reg_r[wd];
        alu_b = {6'h00, lit};
        res_we = 1'b1;
        fmask = 5'h1F;
      end
      `DCAD_OP_ADD_WWW, `DCAD_OP_ADD_WITH_CARRY_OP_WWW: begin
        res_we = 1'b1;
        fmask = 5'h1F;
      end
      `DCAD_OP_ADD_L5, `DCAD_OP_ADD_WITH_CARRY_OP_L5: begin
        alu_b = {11'h000, lit[4:0]};
        res_we = 1'b1;
        fmask = 5'h1F;
      end
      `DCAD_OP_AND_WWW, `DCAD_OP_AND_L10: begin
        if (op == `DCAD_OP_AND_L10) begin
          alu_a = default_work_reg_r[wd];
          alu_b = {6'h00, lit};
        end
        alu_sel = `DCAD_ALU_AND;
        res_we = 1'b1;
        fmask = 5'h14;
      end
      `DCAD_OP_ASR_F: begin
        alu_a = freg_r;
        alu_sel = `DCAD_ALU_ASR1;
        dst = 4'd0;
        res_we = to_default_work_reg;
        res_to_f = !to_default_work_reg;
        fmask = 5'h1D;
      end
      `DCAD_OP_ASR_W: begin
        alu_sel = `DCAD_ALU_ASR1;
        res_we = 1'b1;
        fmask = 5'h1D;
      end
      `DCAD_OP_ASR_BW, `DCAD_OP_ASR_BL: begin
        alu_a = default_work_reg_r[wa];
        alu_sh = (op == `DCAD_OP_ASR_BL) ? lit[4:0] : default_work_reg_r[wb][4:0];
        alu_sel = `DCAD_ALU_ASRN;
        res_we = 1'b1;
        fmask = 5'h14;
      end
      default: begin
        fmask = 5'h00;
      end
    endcase
  end

  dcad_alu u_alu (
    .a_in(alu_a),
    .b_in(alu_b),
    .carry_in(is_add_with_carry_op && status_r[`DCAD_ST_C]),
    .shamt_in(alu_sh),
    .sel_in(alu_sel),
    .res_out(alu_res),
    .flags_out(alu_flags)
  );

  // Shifted signed add to the selected accumulator.
  wire [3:0] sl = lit[3:0];
  wire [3:0] sl_neg = 4'h0 - sl;
  wire [15:0] acc_src = default_work_reg_r[wa];
  wire [31:0] acc_ext = {{16{acc_src[15]}}, acc_src};
  // Right shift kept apart so the mixed-sign select cannot make it logical.
  wire [31:0] acc_asr = $signed(acc_ext) >>> sl[2:0];
  wire [31:0] acc_shv = sl[3] ? (acc_ext << sl_neg) : acc_asr;
  wire [31:0] acc_cur = acc_b ? accb_r : acca_r;
  wire [32:0] acc_sum = {acc_cur[31], acc_cur} + {acc_shv[31], acc_shv};
  wire acc_ovf = acc_sum[32] != acc_sum[31];
  wire [31:0] acc_sat = !acc_ovf ? acc_sum[31:0] :
    (acc_sum[32] ? `DCAD_ACC_MIN : `DCAD_ACC_MAX);
  wire [31:0] prod = $signed(default_work_reg_r[wa]) * $signed(default_work_reg_r[wb]);

  // Branch condition on the current flags.
  wire n_eq_ov = status_r[`DCAD_ST_N] == status_r[`DCAD_ST_OV];
  reg br_cond;
  always @* begin
    case (lit[3:0])
      `DCAD_CC_C: br_cond = status_r[`DCAD_ST_C];
      `DCAD_CC_GE: br_cond = n_eq_ov;
      `DCAD_CC_GEU: br_cond = status_r[`DCAD_ST_C];
      `DCAD_CC_GT: br_cond = n_eq_ov && !status_r[`DCAD_ST_Z];
      `DCAD_CC_Z: br_cond = status_r[`DCAD_ST_Z];
      default: br_cond = 1'b0;
    endcase
  end
  wire br_take = exec && (op == `DCAD_OP_BRA_CC) && br_cond;

  // Sequencer: one execute cycle, one more for a taken branch.
  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = cmd_wr ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = br_take ? ST_BR2 : ST_IDLE;
      ST_BR2: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Command, configuration, status and accumulator registers.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      cmd_r <= `DCAD_RST_WORD;
      status_r <= 13'h0000;
      freg_r <= `DCAD_RST_HALF;
      acca_r <= `DCAD_RST_WORD;
      accb_r <= `DCAD_RST_WORD;
      pfcfg_r <= 18'h0_0000;
      pf_x_addr_out <= `DCAD_RST_HALF;
      pf_y_addr_out <= `DCAD_RST_HALF;
      branch_taken_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      branch_taken_out <= br_take;
      if (cmd_wr && idle) begin
        cmd_r <= pwdata_in;
        pf_x_addr_out <= (xmode == `DCAD_PF_INDEX) ?
          default_work_reg_r[xptr] + default_work_reg_r[12] : default_work_reg_r[xptr];
        pf_y_addr_out <= (ymode == `DCAD_PF_INDEX) ?
          default_work_reg_r[yptr] + default_work_reg_r[12] : default_work_reg_r[yptr];
      end
      if (cmd_wr && !idle)
        status_r[`DCAD_ST_REFUSED] <= 1'b1;
      if (wr_acc && paddr_in == `DCAD_OFS_STATUS) begin
        status_r[8:0] <= pwdata_in[8:0];
        if (pwdata_in[`DCAD_ST_ILLEGAL])
          status_r[`DCAD_ST_ILLEGAL] <= 1'b0;
        if (pwdata_in[`DCAD_ST_REFUSED])
          status_r[`DCAD_ST_REFUSED] <= 1'b0;
      end
      if (wr_acc && paddr_in == `DCAD_OFS_FREG)
        freg_r <= pwdata_in[15:0];
      if (wr_acc && paddr_in == `DCAD_OFS_ACCA)
        acca_r <= pwdata_in;
      if (wr_acc && paddr_in == `DCAD_OFS_ACCB)
        accb_r <= pwdata_in;
      if (wr_acc && paddr_in == `DCAD_OFS_PFCFG)
        pfcfg_r <= pwdata_in[17:0];
      // Execution results win over a software write in the same cycle.
      if (exec) begin
        status_r[`DCAD_ST_ILLEGAL] <= illegal ||
          status_r[`DCAD_ST_ILLEGAL];
        if (op == `DCAD_OP_BRA_CC)
          status_r[`DCAD_ST_TAKEN] <= br_cond;
        for (i = 0; i < 4; i = i + 1)
          if (fmask[i])
            status_r[i] <= alu_flags[i];
        if (fmask[`DCAD_ST_Z])
          status_r[`DCAD_ST_Z] <= alu_flags[`DCAD_ST_Z] &&
            (!is_add_with_carry_op || status_r[`DCAD_ST_Z]);
        if (res_to_f)
          freg_r <= alu_res;
        if (op == `DCAD_OP_ADD_ACC) begin
          if (acc_b) begin
            accb_r <= acc_sat;
            status_r[`DCAD_ST_OB] <= acc_ovf;
            status_r[`DCAD_ST_SB] <= acc_ovf || status_r[`DCAD_ST_SB];
          end else begin
            acca_r <= acc_sat;
            status_r[`DCAD_ST_OA] <= acc_ovf;
            status_r[`DCAD_ST_SA] <= acc_ovf || status_r[`DCAD_ST_SA];
          end
        end
        if (mpy_go) begin
          if (acc_b)
            accb_r <= prod;
          else
            acca_r <= prod;
        end
      end
    end
  end

  // Working register file: software, result, pointer and prefetch writes.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (j = 0; j < 16; j = j + 1)
        default_work_reg_r[j] <= `DCAD_RST_HALF;
    end else begin
      for (j = 0; j < 16; j = j + 1) begin
        if (wr_acc && w_hit && w_idx == j)
          default_work_reg_r[j] <= pwdata_in[15:0];
        if (exec && res_we && dst == j)
          default_work_reg_r[j] <= alu_res;
        if (pf_x_en_out && xptr == j && xmode != `DCAD_PF_INDEX)
          default_work_reg_r[j] <= default_work_reg_r[j] + pf_delta(xmode);
        if (pf_y_en_out && yptr == j && ymode != `DCAD_PF_INDEX)
          default_work_reg_r[j] <= default_work_reg_r[j] + pf_delta(ymode);
        if (pf_x_en_out && xd == j)
          default_work_reg_r[j] <= pf_x_data_in;
        if (pf_y_en_out && yd == j)
          default_work_reg_r[j] <= pf_y_data_in;
      end
    end
  end

  // Read data and error are captured in the setup phase.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= `DCAD_RST_WORD;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      pslverr_out <= 1'b0;
      prdata_out <= `DCAD_RST_WORD;
      if (w_hit)
        prdata_out <= {16'h0000, default_work_reg_r[w_idx]};
      else
        case (paddr_in)
          `DCAD_OFS_CMD: prdata_out <= cmd_r;
          `DCAD_OFS_STATUS:
            prdata_out <= {19'h0_0000, status_r[12:10], busy_out,
              status_r[8:0]};
          `DCAD_OFS_FREG: prdata_out <= {16'h0000, freg_r};
          `DCAD_OFS_ACCA: prdata_out <= acca_r;
          `DCAD_OFS_ACCB: prdata_out <= accb_r;
          `DCAD_OFS_PFCFG: prdata_out <= {14'h0000, pfcfg_r};
          default: pslverr_out <= 1'b1;
        endcase
    end
  end

endmodule

// File: dv/dcad_pf_mem.sv
// Data-space model that answers the prefetch reads of the datapath.
module dcad_pf_mem (
  // Clock.
  input wire clk_in,
  // Read request and answer.
  input wire en_in,
  input wire [15:0] addr_in,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_r = 16'h0000;
  // A read returns a scramble of the address; between reads the line shows
  // the inverse of the last word, so stale data can never pass as fresh.
  always_comb data_out = en_in ? (addr_in ^ 16'h5A5A) : ~last_r;
  // Remember the last word handed out.
  always @(posedge clk_in) if (en_in) last_r <= data_out;
endmodule

// File: dv/dcad_core_sva.sv
// Port-level assertions for the DSP ALU operand datapath core.
module dcad_core_sva (
  // Clock and reset.
  input wire clk_in,
  input wire rst_n_in,
  // APB slave.
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  // Prefetch ports.
  input wire pf_x_en_out,
  input wire [15:0] pf_x_addr_out,
  input wire [15:0] pf_x_data_in,
  input wire pf_y_en_out,
  input wire [15:0] pf_y_addr_out,
  input wire [15:0] pf_y_data_in,
  // Core status.
  input wire busy_out,
  input wire branch_taken_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // A taken pulse only closes a branch that has been busy for two cycles.
  a_taken_busy: assert property (
    branch_taken_out |-> busy_out && $past(busy_out))
    else $error("taken pulse outside a busy branch");
  a_taken_last: assert property (
    branch_taken_out |=> !busy_out && !branch_taken_out)
    else $error("branch lasted beyond its second cycle");
  a_busy_short: assert property (
    $rose(busy_out) |-> ##[1:2] !busy_out)
    else $error("operation busy longer than two cycles");
  a_second_cycle: assert property (
    busy_out && $past(busy_out) |-> branch_taken_out)
    else $error("second busy cycle without a taken branch");
  // Prefetch strobes belong to a single execute cycle.
  a_pfx_exec: assert property (
    pf_x_en_out |-> busy_out && !branch_taken_out)
    else $error("x prefetch outside an execute cycle");
  a_pfy_exec: assert property (
    pf_y_en_out |-> busy_out && !branch_taken_out)
    else $error("y prefetch outside an execute cycle");
  a_pf_single: assert property (
    (pf_x_en_out || pf_y_en_out) |=> !(pf_x_en_out || pf_y_en_out))
    else $error("prefetch strobe longer than one cycle");
  // Addresses latch at acceptance and must hold for the whole operation.
  a_pf_addr_held: assert property (
    busy_out |=> $stable(pf_x_addr_out) && $stable(pf_y_addr_out))
    else $error("prefetch address moved while busy");
  c_taken: cover property (branch_taken_out);
  c_dual_pf: cover property (pf_x_en_out && pf_y_en_out);
  c_apb_err: cover property (pslverr_out);
endmodule

// File: dv/dsp_core_alu_operand_datapath_bench.sv
// Bench driving the datapath core over APB with checked command steps.
module dsp_core_alu_operand_datapath_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  wire pready_out, pslverr_out, pf_x_en_out, pf_y_en_out;
  wire busy_out, branch_taken_out;
  wire [31:0] prdata_out;
  wire [15:0] pf_x_addr_out, pf_y_addr_out, pf_x_data_in, pf_y_data_in;
  int mismatches = 0;
  int n_compared = 0;
  int bcnt = 0;
  int pcnt = 0;
  logic [31:0] rd;
  logic err;
  logic tk;
  logic [4:0] fl [4] = '{5'h01, 5'h04, 5'h10, 5'h0C};

  dcad_core i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .pf_x_en_out(pf_x_en_out), .pf_x_addr_out(pf_x_addr_out),
    .pf_x_data_in(pf_x_data_in), .pf_y_en_out(pf_y_en_out),
    .pf_y_addr_out(pf_y_addr_out), .pf_y_data_in(pf_y_data_in),
    .busy_out(busy_out), .branch_taken_out(branch_taken_out));
  dcad_pf_mem i_pfx (.clk_in(clk_in), .en_in(pf_x_en_out),
    .addr_in(pf_x_addr_out), .data_out(pf_x_data_in));
  dcad_pf_mem i_pfy (.clk_in(clk_in), .en_in(pf_y_en_out),
    .addr_in(pf_y_addr_out), .data_out(pf_y_data_in));

  // Clock and counts of busy cycles and x prefetch strobes.
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    bcnt <= bcnt + busy_out;
    pcnt <= pcnt + pf_x_en_out;
  end

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; keep leaves psel up for a back-to-back setup.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input bit keep);
    int k;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    if (k == 50) begin
      mismatches++;
      conclude();
    end
    rd = prdata_out;
    err = pslverr_out;
    if (!keep) begin
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask

  function automatic logic [31:0] mk(input logic [4:0] op,
    input logic [3:0] a, b, d, input logic [9:0] l, input logic w);
    return {3'h0, w, 1'b0, l, d, b, a, op};
  endfunction

  // Issue a command, then check busy cycles, strobes, target and flags.
  task automatic s(input logic [31:0] c, input logic [11:0] ra,
    input logic [15:0] ev, input logic [7:0] es,
    input int cyc = 1, input int pf = 0);
    int b0;
    int p0;
    int k;
    b0 = bcnt;
    p0 = pcnt;
    apb(1'b1, 12'h000, c, 1'b0);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (busy_out !== 1'b0 && k < 20);
    if (k == 20) begin
      mismatches++;
      conclude();
    end
    @(posedge clk_in);
    if (cyc < 9) chk(bcnt - b0, cyc);
    chk(pcnt - p0, pf);
    apb(1'b0, ra, 32'h0000_0000, 1'b0);
    chk(rd, {16'h0000, ev});
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    chk({rd[12:10], rd[4:0]}, es);
    if (rd[12] || rd[10]) apb(1'b1, 12'h004, rd, 1'b0);
  endtask

  // An illegal multiply leaves register eleven and the strobes alone.
  task automatic bad(input logic [4:0] op, input logic [3:0] a, b);
    s(mk(op, a, b, 4'h0, 10'h000, 1'b0), 12'h06C, 16'h2004, 8'h20, 9);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h07C, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000, 1'b0);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 12'h040, 32'h0000_FF01, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_00FF, 1'b0);
    apb(1'b1, 12'h04C, 32'h0000_7FFF, 1'b0);
    apb(1'b1, 12'h05C, 32'h0000_0004, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_0001, 1'b0);
    s(mk(5'h01, 4'h0, 4'h0, 4'h0, 10'h000, 1), 12'h040, 16'h0001, 8'h03);
    apb(1'b0, 12'h008, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_00FF);
    s(mk(5'h03, 4'h3, 4'h3, 4'h3, 10'h3FF, 0), 12'h04C, 16'h83FF, 8'h0E);
    s(mk(5'h07, 4'h3, 4'h0, 4'h2, 10'h01F, 0), 12'h048, 16'h841E, 8'h06);
    s(mk(5'h04, 4'h2, 4'h3, 4'h1, 10'h000, 0), 12'h044, 16'h081D, 8'h0B);
    s(mk(5'h0C, 4'h2, 4'h0, 4'h5, 10'h000, 0), 12'h054, 16'hC20F, 8'h06);
    s(mk(5'h0B, 4'h0, 4'h0, 4'h0, 10'h000, 1), 12'h040, 16'h007F, 8'h03);
    s(mk(5'h0D, 4'h2, 4'h7, 4'h6, 10'h000, 0), 12'h058, 16'hF841, 8'h07);
    s(mk(5'h0E, 4'h2, 4'h0, 4'h6, 10'h00F, 0), 12'h058, 16'hFFFF, 8'h07);
    s(mk(5'h09, 4'h2, 4'h0, 4'hC, 10'h000, 0), 12'h070, 16'h001E, 8'h03);
    // A negative source shifted right by one keeps its sign in the sum.
    s(mk(5'h08, 4'h3, 4'h0, 4'h0, 10'h001, 0), 12'h008, 16'h00FF, 8'h03);
    apb(1'b0, 12'h00C, 32'h0000_0000, 1'b0);
    chk(rd, 32'hFFFF_C1FF);
    // Every branch condition against several flag patterns.
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 5; j++) begin
        apb(1'b1, 12'h004, {27'h0, fl[i]}, 1'b0);
        case (j)
          0, 2: tk = fl[i][0];
          1: tk = !(fl[i][2] ^ fl[i][3]);
          3: tk = !fl[i][4] && !(fl[i][2] ^ fl[i][3]);
          default: tk = fl[i][4];
        endcase
        s(mk(5'h11, 4'h0, 4'h0, 4'h0, j[9:0], 0), 12'h008, 16'h00FF,
          {1'b0, tk, 1'b0, fl[i]}, tk ? 2 : 1);
      end
    end
    apb(1'b1, 12'h004, 32'h0000_0000, 1'b0);
    s(mk(5'h02, 4'hF, 4'h0, 4'hF, 10'h3FF, 0), 12'h07C, 16'h03FF, 8'h00);
    apb(1'b1, 12'h060, 32'h0000_1000, 1'b0);
    apb(1'b1, 12'h06C, 32'h0000_2000, 1'b0);
    apb(1'b1, 12'h064, 32'h0000_0100, 1'b0);
    apb(1'b1, 12'h014, 32'h0001_6481, 1'b0);
    s(mk(5'h0F, 4'h6, 4'h6, 4'h0, 0, 0), 12'h050, 16'h4A5A, 8'h00, 1, 1);
    apb(1'b0, 12'h00C, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h054, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_7A5A);
    apb(1'b0, 12'h06C, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_2002);
    s(mk(5'h10, 4'h4, 4'h7, 4'h0, 0, 0), 12'h054, 16'h7A58, 8'h00, 1, 1);
    bad(5'h0F, 4'h4, 4'h5);
    bad(5'h10, 4'h5, 4'h4);
    bad(5'h10, 4'h3, 4'h4);
    bad(5'h10, 4'h4, 4'h4);
    apb(1'b1, 12'h014, 32'h0001_6488, 1'b0);
    bad(5'h0F, 4'h6, 4'h6);
    apb(1'b1, 12'h014, 32'h0001_5081, 1'b0);
    bad(5'h0F, 4'h6, 4'h6);
    apb(1'b1, 12'h014, 32'h0001_6461, 1'b0);
    bad(5'h0F, 4'h6, 4'h6);
    // Indexed X pointer with a Y pointer stepping down by six.
    apb(1'b1, 12'h014, 32'h0001_6E98, 1'b0);
    s(mk(5'h0F, 4'h6, 4'h6, 4'h0, 0, 0), 12'h050, 16'h5B44, 8'h00, 1, 1);
    chk({16'h0000, pf_x_addr_out}, 32'h0000_011E);
    apb(1'b0, 12'h06C, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_1FFE);
    // A command written during a taken branch's second cycle is refused.
    apb(1'b1, 12'h004, 32'h0000_0001, 1'b0);
    apb(1'b1, 12'h000, mk(5'h11, 4'h0, 4'h0, 4'h0, 2, 0), 1'b1);
    apb(1'b1, 12'h000, mk(5'h02, 4'hD, 4'h0, 4'hD, 5, 0), 1'b0);
    apb(1'b0, 12'h074, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    chk({rd[12:10], rd[4:0]}, 8'hC1);
    conclude();
  end
endmodule

bind dcad_core dcad_core_sva i_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .pf_x_en_out(pf_x_en_out), .pf_x_addr_out(pf_x_addr_out),
  .pf_x_data_in(pf_x_data_in), .pf_y_en_out(pf_y_en_out),
  .pf_y_addr_out(pf_y_addr_out), .pf_y_data_in(pf_y_data_in),
  .busy_out(busy_out), .branch_taken_out(branch_taken_out));
